/* File: rtl/fp_exc_pkg.sv */
/*
 * Shared constants for the floating-point exception dispatch block:
 * condition and enable bit positions, register offsets, reset values, timing.
 * Assumes a single 100 MHz core clock.
 */
package fp_exc_pkg;

	// Condition record bit positions
	localparam int COND_W      = 12;
	localparam int C_VXSNAN    = 0;
	localparam int C_VXISI     = 1;
	localparam int C_VXIDI     = 2;
	localparam int C_VXZDZ     = 3;
	localparam int C_VXIMZ     = 4;
	localparam int C_VXVC      = 5;
	localparam int C_VXSQRT    = 6;
	localparam int C_VXCVI     = 7;
	localparam int C_ZX        = 8;
	localparam int C_OX        = 9;
	localparam int C_UX        = 10;
	localparam int C_XX        = 11;
	localparam int INV_W       = 8;
	localparam int REC_FX      = 12;
	localparam int REC_FEX     = 13;

	// Enable bit positions
	localparam int EN_W        = 5;
	localparam int EN_VE       = 0;
	localparam int EN_OE       = 1;
	localparam int EN_UE       = 2;
	localparam int EN_ZE       = 3;
	localparam int EN_XE       = 4;

	// Interrupt status bits
	localparam int IRQ_W       = 3;
	localparam int IRQ_TRAP    = 0;
	localparam int IRQ_IGNORED = 1;
	localparam int IRQ_SUMMARY = 2;

	// Register bus
	localparam int ADDR_W      = 8;
	localparam int BUS_W       = 32;
	localparam logic [ADDR_W-1:0] REG_RECORD     = 8'h00;
	localparam logic [ADDR_W-1:0] REG_ENABLE     = 8'h04;
	localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h08;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK   = 8'h0C;

	// Reset values
	localparam logic [COND_W-1:0] RECORD_RST = 12'h000;
	localparam logic [EN_W-1:0]   ENABLE_RST = 5'h00;
	localparam logic [IRQ_W-1:0]  MASK_RST   = 3'h0;

	// Timing
	localparam int CNT_W          = 8;
	localparam int CLK_PERIOD_NS  = 10;
	localparam int SYNC_DRAIN_NS  = 40;
	localparam int SYNC_DRAIN_CYC = (SYNC_DRAIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_WAIT_OLDER,
		ST_TRAP,
		ST_DRAIN
	} disp_state_t;

endpackage

/* File: rtl/fp_cond_filter.sv */
/*
 * Legalises the set of condition bits one instruction may raise at once.
 * Assumes the datapath flags the operation class of the instruction.
 */
`timescale 1ns/1ps
module fp_cond_filter
	import fp_exc_pkg::*;
(
	input  wire logic [fp_exc_pkg::COND_W-1:0] rawCond,
	input  wire logic                          opMulAdd,
	input  wire logic                          opCmpOrd,
	input  wire logic                          opCvtInt,
	output logic      [fp_exc_pkg::COND_W-1:0] legalCond
);
	logic [INV_W-1:0] invRaw;
	logic [INV_W-1:0] invLowest;
	logic [INV_W-1:0] invSeen;
	logic [INV_W-1:0] invPartner;
	logic [INV_W-1:0] invOut;
	logic             snan;

	assign invRaw = rawCond[INV_W-1:0];
	assign snan   = invRaw[C_VXSNAN];

	// Keep only the first raised invalid kind when the pair is not allowed
	genvar i;
	generate
		for (i = 0; i < INV_W; i++) begin : g_low
			if (i == 0) begin : g_first
				assign invSeen[i]   = invRaw[i];
				assign invLowest[i] = invRaw[i];
			end else begin : g_rest
				assign invSeen[i]   = invSeen[i-1] | invRaw[i];
				assign invLowest[i] = invRaw[i] & ~invSeen[i-1];
			end
		end
	endgenerate

	assign invPartner = '0 | ({{(INV_W-1){1'b0}}, 1'b1} << C_VXIMZ) & {INV_W{opMulAdd}}
		| ({{(INV_W-1){1'b0}}, 1'b1} << C_VXVC) & {INV_W{opCmpOrd}}
		| ({{(INV_W-1){1'b0}}, 1'b1} << C_VXCVI) & {INV_W{opCvtInt}};
	assign invOut = snan ? (invLowest | (invRaw & invPartner)) : invLowest;

	// Inexact rides along with overflow or underflow; the two never together
	assign legalCond[INV_W-1:0] = invOut;
	assign legalCond[C_ZX]      = rawCond[C_ZX];
	assign legalCond[C_OX]      = rawCond[C_OX];
	assign legalCond[C_UX]      = rawCond[C_UX] & ~rawCond[C_OX];
	assign legalCond[C_XX]      = rawCond[C_XX];

endmodule

/* File: rtl/fp_result_select.sv */
/*
 * Chooses suppression or delivery, and trap-enabled or default value,
 * from the enable bits only. Assumes the datapath supplies both candidates.
 */
`timescale 1ns/1ps
module fp_result_select
	import fp_exc_pkg::*;
#(
	parameter int DATA_W = 64
) (
	input  wire logic [fp_exc_pkg::COND_W-1:0] cond,
	input  wire logic [fp_exc_pkg::EN_W-1:0]   enable,
	input  wire logic [DATA_W-1:0]             trapValue,
	input  wire logic [DATA_W-1:0]             defaultValue,
	output logic                               suppress,
	output logic      [DATA_W-1:0]             value,
	output logic                               enabledExc
);
	logic invAny;
	logic enDeliver;

	assign invAny     = |cond[INV_W-1:0];
	assign suppress   = (invAny & enable[EN_VE]) | (cond[C_ZX] & enable[EN_ZE]);
	assign enDeliver  = (cond[C_OX] & enable[EN_OE]) | (cond[C_UX] & enable[EN_UE])
		| (cond[C_XX] & enable[EN_XE]);
	// Mode bits never reach this path
	assign value      = enDeliver ? trapValue : defaultValue;
	assign enabledExc = suppress | enDeliver;

endmodule

/* File: rtl/fp_exception_dispatch.sv */
/*
 * Floating-point exception dispatch: condition record, enables, result policy,
 * precise handler request and record-drain for status access and sync.
 * Assumes instructions arrive in program order, one at a time, and that the
 * completion logic reports when all older instructions have completed.
 */
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
//
// Operation
// - Inexact may accompany overflow or underflow in one instruction.
// - SNaN invalid may pair with inf*zero, compare or convert invalid by op.
// - Enabled invalid or zero-divide suppresses the instruction's write.
// - All other conditions deliver a result to the destination.
// - Enable set selects the trap-enabled result value.
// - Enable clear selects the default result value.
// - Mode bits both zero: never request the handler, still record.
// - Precise mode requests the handler at the excepting instruction.
// - The two mode bits are ORed; either set means precise.
// - Disabled conditions never request the handler.
// - Result store and value depend only on enable bits.
// - Handler only after older complete and before younger execute.
// - Status access waits until earlier conditions are recorded.
// - Sync also drains pending conditions, stalling longer.
// - Summary bit sets on any zero-to-one condition change or software set.
// - Enabled summary is high while any enabled condition is recorded.
module fp_exception_dispatch
	import fp_exc_pkg::*;
#(
	parameter int DATA_W = 64,
	parameter int TAG_W  = 6
) (
	input  wire logic                          clk,
	input  wire logic                          rst,
	input  wire logic                          ce,
	input  wire logic [fp_exc_pkg::ADDR_W-1:0] regAddr,
	input  wire logic [fp_exc_pkg::BUS_W-1:0]  regWrData,
	input  wire logic                          regWr,
	input  wire logic                          regRd,
	output logic      [fp_exc_pkg::BUS_W-1:0]  regRdData,
	input  wire logic                          inValid,
	input  wire logic [TAG_W-1:0]              inTag,
	input  wire logic [fp_exc_pkg::COND_W-1:0] inCond,
	input  wire logic                          opMulAdd,
	input  wire logic                          opCmpOrd,
	input  wire logic                          opCvtInt,
	input  wire logic [DATA_W-1:0]             trapValue,
	input  wire logic [DATA_W-1:0]             defaultValue,
	output logic                               inReady,
	input  wire logic                          fpExcModeBit0,
	input  wire logic                          fpExcModeBit1,
	input  wire logic                          olderDone,
	input  wire logic                          trapAck,
	input  wire logic                          fpscrAccess,
	input  wire logic                          syncReq,
	output logic                               accessGrant,
	output logic                               wbValid,
	output logic      [TAG_W-1:0]              wbTag,
	output logic      [DATA_W-1:0]             wbData,
	output logic                               wbSuppress,
	output logic                               excReq,
	output logic      [TAG_W-1:0]              excTag,
	output logic                               flushYounger,
	output logic                               irq
);
	import fp_exc_pkg::*;

	disp_state_t       state;
	disp_state_t       next_state;
	logic [COND_W-1:0] legalCond;
	logic              selSuppress;
	logic [DATA_W-1:0] selValue;
	logic              selEnabled;
	logic              accept;
	logic              preciseMode;
	logic              trapNow;

	logic [COND_W-1:0] record;
	logic              fxBit;
	logic              fexBit;
	logic [EN_W-1:0]   enable;
	logic [IRQ_W-1:0]  irqStatus;
	logic [IRQ_W-1:0]  irqMask;
	logic [COND_W-1:0] pendCond;
	logic              pendValid;
	logic [TAG_W-1:0]  heldTag;
	logic [CNT_W-1:0]  drainCnt;

	fp_cond_filter u_filter (
		.rawCond   (inCond),
		.opMulAdd  (opMulAdd),
		.opCmpOrd  (opCmpOrd),
		.opCvtInt  (opCvtInt),
		.legalCond (legalCond)
	);

	fp_result_select #(
		.DATA_W (DATA_W)
	) u_select (
		.cond         (legalCond),
		.enable       (enable),
		.trapValue    (trapValue),
		.defaultValue (defaultValue),
		.suppress     (selSuppress),
		.value        (selValue),
		.enabledExc   (selEnabled)
	);

	assign preciseMode = fpExcModeBit0 | fpExcModeBit1;
	assign accept      = inValid & inReady;
	// Ignore mode records but never traps
	assign trapNow     = accept & selEnabled & preciseMode;

	// Register decode
	logic wrRecord;
	logic wrEnable;
	logic wrStatus;
	logic wrMask;
	assign wrRecord = regWr & (regAddr == REG_RECORD);
	assign wrEnable = regWr & (regAddr == REG_ENABLE);
	assign wrStatus = regWr & (regAddr == REG_IRQ_STATUS);
	assign wrMask   = regWr & (regAddr == REG_IRQ_MASK);

	// Record update: hardware set wins over a software write in the same cycle
	logic [COND_W-1:0] recBase;
	logic [COND_W-1:0] mergeCond;
	logic [COND_W-1:0] next_record;
	logic              next_fx;
	logic [EN_W-1:0]   next_enable;
	logic [COND_W-1:0] enExpand;
	logic              next_fex;
	logic              newlySet;

	assign recBase     = wrRecord ? regWrData[COND_W-1:0] : record;
	assign mergeCond   = pendValid ? pendCond : '0;
	assign next_record = recBase | mergeCond;
	assign newlySet    = |(mergeCond & ~recBase);
	assign next_fx     = (wrRecord ? regWrData[REC_FX] : fxBit) | newlySet;
	assign next_enable = wrEnable ? regWrData[EN_W-1:0] : enable;
	assign enExpand    = {next_enable[EN_XE], next_enable[EN_UE], next_enable[EN_OE],
		next_enable[EN_ZE], {INV_W{next_enable[EN_VE]}}};
	assign next_fex    = |(next_record & enExpand);

	// Interrupt events; set wins over write-one-to-clear
	logic [IRQ_W-1:0] irqEvent;
	logic [IRQ_W-1:0] next_irqStatus;
	logic [IRQ_W-1:0] next_irqMask;
	logic             next_irq;
	assign irqEvent[IRQ_TRAP]    = trapNow;
	assign irqEvent[IRQ_IGNORED] = accept & selEnabled & ~preciseMode;
	assign irqEvent[IRQ_SUMMARY] = next_fx & ~fxBit;
	assign next_irqStatus = (irqStatus & ~(wrStatus ? regWrData[IRQ_W-1:0] : '0)) | irqEvent;
	assign next_irqMask   = wrMask ? regWrData[IRQ_W-1:0] : irqMask;
	assign next_irq       = |(next_irqStatus & next_irqMask);

	// Read mux; data stands only in the cycle after the strobe
	logic [BUS_W-1:0] readWord;
	logic [BUS_W-1:0] next_rdData;
	assign readWord = (regAddr == REG_RECORD) ?
			{{(BUS_W-COND_W-2){1'b0}}, fexBit, fxBit, record} :
		(regAddr == REG_ENABLE) ? {{(BUS_W-EN_W){1'b0}}, enable} :
		(regAddr == REG_IRQ_STATUS) ? {{(BUS_W-IRQ_W){1'b0}}, irqStatus} :
		(regAddr == REG_IRQ_MASK) ? {{(BUS_W-IRQ_W){1'b0}}, irqMask} : '0;
	assign next_rdData = regRd ? readWord : '0;

	// Sequencing
	logic             drainIdle;
	logic [CNT_W-1:0] next_drainCnt;
	logic             next_grant;
	assign drainIdle = ~pendValid & (drainCnt == '0);

	always_comb begin
		next_state    = state;
		next_drainCnt = drainCnt;
		next_grant    = 1'b0;
		unique case (state)
			ST_RUN: begin
				if (trapNow) begin
					next_state = ST_WAIT_OLDER;
				end else if (syncReq) begin
					next_state    = ST_DRAIN;
					next_drainCnt = CNT_W'(SYNC_DRAIN_CYC);
				end else if (fpscrAccess) begin
					next_state = ST_DRAIN;
				end
			end
			ST_WAIT_OLDER: begin
				if (olderDone) begin
					next_state = ST_TRAP;
				end
			end
			ST_TRAP: begin
				if (trapAck) begin
					next_state = ST_RUN;
				end
			end
			ST_DRAIN: begin
				if (drainCnt != '0) begin
					next_drainCnt = drainCnt - 1'b1;
				end
				if (drainIdle) begin
					next_state = ST_RUN;
					next_grant = 1'b1;
				end
			end
		endcase
	end

	// Younger instructions held off until the handler request is taken
	logic next_inReady;
	assign next_inReady = (next_state == ST_RUN);

	always_ff @(posedge clk) begin
		if (rst) begin
			state     <= ST_RUN;
			inReady   <= 1'b0;
			drainCnt  <= '0;
			accessGrant <= 1'b0;
		end else if (ce) begin
			state     <= next_state;
			inReady   <= next_inReady;
			drainCnt  <= next_drainCnt;
			accessGrant <= next_grant;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			record    <= RECORD_RST;
			fxBit     <= 1'b0;
			fexBit    <= 1'b0;
			enable    <= ENABLE_RST;
			irqStatus <= '0;
			irqMask   <= MASK_RST;
			irq       <= 1'b0;
			regRdData <= '0;
		end else if (ce) begin
			record    <= next_record;
			fxBit     <= next_fx;
			fexBit    <= next_fex;
			enable    <= next_enable;
			irqStatus <= next_irqStatus;
			irqMask   <= next_irqMask;
			irq       <= next_irq;
			regRdData <= next_rdData;
		end
	end

	// Conditions land in the record two cycles after the instruction, a cycle after writeback
	always_ff @(posedge clk) begin
		if (rst) begin
			pendValid <= 1'b0;
			pendCond  <= '0;
		end else if (ce) begin
			pendValid <= accept;
			pendCond  <= legalCond;
		end
	end

	// Writeback stage; suppressed entries carry no data
	always_ff @(posedge clk) begin
		if (rst) begin
			wbValid    <= 1'b0;
			wbTag      <= '0;
			wbData     <= '0;
			wbSuppress <= 1'b0;
		end else if (ce) begin
			wbValid    <= accept;
			wbTag      <= inTag;
			wbData     <= selSuppress ? '0 : selValue;
			wbSuppress <= accept & selSuppress;
		end
	end

	// Handler request stands from older-done until acknowledged
	always_ff @(posedge clk) begin
		if (rst) begin
			heldTag      <= '0;
			excReq       <= 1'b0;
			excTag       <= '0;
			flushYounger <= 1'b0;
		end else if (ce) begin
			if (trapNow) begin
				heldTag <= inTag;
			end
			excReq       <= (next_state == ST_TRAP);
			excTag       <= (next_state == ST_TRAP) ? heldTag : '0;
			flushYounger <= (state == ST_WAIT_OLDER) & olderDone;
		end
	end

endmodule

/* File: tb/fp_dispatch_chk.sv */
/*
 * Port-level checks on the floating-point exception dispatch block.
 * Assumes ce stays high while instructions flow; bound from the foot of this file.
 */
`timescale 1ns/1ps
module fp_dispatch_chk
	import fp_exc_pkg::*;
#(
	parameter int DATA_W = 64,
	parameter int TAG_W  = 6
) (
	input wire logic				clk,
	input wire logic				rst,
	input wire logic				ce,
	input wire logic [fp_exc_pkg::ADDR_W-1:0]	regAddr,
	input wire logic [fp_exc_pkg::BUS_W-1:0]	regWrData,
	input wire logic				regWr,
	input wire logic				inValid,
	input wire logic [TAG_W-1:0]			inTag,
	input wire logic [fp_exc_pkg::COND_W-1:0]	inCond,
	input wire logic [DATA_W-1:0]			trapValue,
	input wire logic [DATA_W-1:0]			defaultValue,
	input wire logic				inReady,
	input wire logic				fpExcModeBit0,
	input wire logic				fpExcModeBit1,
	input wire logic				olderDone,
	input wire logic				trapAck,
	input wire logic				fpscrAccess,
	input wire logic				syncReq,
	input wire logic				accessGrant,
	input wire logic				wbValid,
	input wire logic [TAG_W-1:0]			wbTag,
	input wire logic [DATA_W-1:0]			wbData,
	input wire logic				wbSuppress,
	input wire logic				excReq,
	input wire logic [TAG_W-1:0]			excTag,
	input wire logic				flushYounger
);
	logic	[EN_W-1:0]	en;
	logic	[TAG_W-1:0]	hTag;
	wire	acc = inValid && inReady && ce;
	wire	sup = (|inCond[INV_W-1:0] && en[EN_VE]) || (inCond[C_ZX] && en[EN_ZE]);
	// Overflow hides underflow, so enabled underflow only counts without overflow
	wire	trp = (inCond[C_OX] && en[EN_OE]) || (inCond[C_XX] && en[EN_XE])
		|| (inCond[C_UX] && !inCond[C_OX] && en[EN_UE]);
	wire	prc = fpExcModeBit0 || fpExcModeBit1;
	always_ff @(posedge clk) begin
		if (rst) begin
			en <= ENABLE_RST;
		end else if (ce && regWr && regAddr == REG_ENABLE) begin
			en <= regWrData[EN_W-1:0];
		end
	end
	always_ff @(posedge clk) begin
		if (acc) begin
			hTag <= inTag;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_wb_tag; acc |=> wbValid && wbTag == $past(inTag); endproperty
	a_wb_tag: assert property (p_wb_tag) else $error("writeback missing or wrong tag");
	property p_sup; acc |=> wbSuppress == $past(sup); endproperty
	a_sup: assert property (p_sup) else $error("suppress decision wrong");
	property p_sup_zero; wbValid && wbSuppress |-> wbData == '0; endproperty
	a_sup_zero: assert property (p_sup_zero) else $error("suppressed data not zero");
	property p_val;
		acc && !sup |=> wbData == ($past(trp) ? $past(trapValue) : $past(defaultValue));
	endproperty
	a_val: assert property (p_val) else $error("result value wrong");
	property p_ignore; acc && !prc |=> !excReq [*3]; endproperty
	a_ignore: assert property (p_ignore) else $error("request in ignore mode");
	property p_disabled; acc && !sup && !trp |=> !excReq [*3]; endproperty
	a_disabled: assert property (p_disabled) else $error("request without enable");
	property p_precise;
		acc && (sup || trp) && prc |=> !inReady ##[0:60] (excReq && excTag == hTag);
	endproperty
	a_precise: assert property (p_precise) else $error("precise request missing");
	property p_older; $rose(excReq) |-> $past(olderDone); endproperty
	a_older: assert property (p_older) else $error("request before older done");
	property p_flush; $rose(excReq) |-> flushYounger; endproperty
	a_flush: assert property (p_flush) else $error("younger not flushed at request");
	property p_flush_pulse; flushYounger |=> !flushYounger; endproperty
	a_flush_pulse: assert property (p_flush_pulse) else $error("flush longer than a pulse");
	property p_block; excReq |-> !inReady; endproperty
	a_block: assert property (p_block) else $error("accepting during request");
	property p_hold; excReq && !trapAck |=> excReq && $stable(excTag); endproperty
	a_hold: assert property (p_hold) else $error("request dropped early");
	property p_drop; excReq && trapAck |=> !excReq; endproperty
	a_drop: assert property (p_drop) else $error("request held after ack");
	property p_grant;
		(fpscrAccess || syncReq) && inReady && !excReq |-> ##[1:20] accessGrant;
	endproperty
	a_grant: assert property (p_grant) else $error("access not granted");
endmodule

bind fp_exception_dispatch fp_dispatch_chk #(.DATA_W(DATA_W), .TAG_W(TAG_W)) chk_inst (
	.clk(clk), .rst(rst), .ce(ce), .regAddr(regAddr), .regWrData(regWrData),
	.regWr(regWr), .inValid(inValid), .inTag(inTag), .inCond(inCond),
	.trapValue(trapValue), .defaultValue(defaultValue), .inReady(inReady),
	.fpExcModeBit0(fpExcModeBit0), .fpExcModeBit1(fpExcModeBit1),
	.olderDone(olderDone), .trapAck(trapAck), .fpscrAccess(fpscrAccess),
	.syncReq(syncReq), .accessGrant(accessGrant), .wbValid(wbValid), .wbTag(wbTag),
	.wbData(wbData), .wbSuppress(wbSuppress), .excReq(excReq), .excTag(excTag),
	.flushYounger(flushYounger)
);

/* File: tb/fp_completion_model.sv */
/*
 * Completion-side partner: reports older work done and takes handler requests.
 * Same clock as the block; slow mode retires in bursts and acknowledges late.
 */
`timescale 1ns/1ps
module fp_completion_model (
	input  wire logic	clk,
	input  wire logic	rst,
	input  wire logic	excReq,
	input  wire logic	slow,
	output logic		olderDone,
	output logic		trapAck
);
	logic	[2:0]	phase;
	logic	[2:0]	hold;
	always_ff @(posedge clk) begin
		if (rst) begin
			phase <= 3'h0;
			hold <= 3'h0;
			trapAck <= 1'b0;
		end else begin
			phase <= phase + 3'h1;
			hold <= (excReq && !trapAck) ? hold + 3'h1 : 3'h0;
			trapAck <= excReq && !trapAck && hold >= (slow ? 3'h5 : 3'h0);
		end
	end
	// Slow: older work only reported done one cycle in eight
	assign olderDone = !slow || phase == 3'h7;
endmodule

/* File: tb/tb_fp_exception_dispatch.sv */
/*
 * Self-checking bench for fp_exception_dispatch with a completion partner.
 * Assumes the shared package; ce is held high throughout.
 */
`timescale 1ns/1ps
module tb_fp_exception_dispatch;
	import fp_exc_pkg::*;
	logic		clk, rst, regWr, regRd, inValid, m0, m1, slow, fpscrAccess, syncReq;
	logic		opMulAdd, opCmpOrd, opCvtInt, olderDone, trapAck, rdPend;
	logic		inReady, accessGrant, wbValid, wbSuppress, excReq, irq;
	logic	[7:0]	regAddr;
	logic	[31:0]	regWrData, regRdData;
	logic	[5:0]	inTag, wbTag, excTag, tag;
	logic	[11:0]	inCond, last;
	logic	[63:0]	trapValue, defaultValue, wbData;
	logic	[70:0]	we;
	logic	[70:0]	wq[$];
	logic	[31:0]	rq[$];
	logic	[4:0]	en;
	logic	[14:0]	cs[8] = '{15'h0A00, 15'h0C00, 15'h0E00, 15'h1011, 15'h2021,
				 15'h4081, 15'h0011, 15'h0006};
	int		errors, n_tests, cyc, seed, i, j, na, ns;

	fp_exception_dispatch fp_exception_dispatch_inst (
		.clk(clk), .rst(rst), .ce(1'b1), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .inValid(inValid),
		.inTag(inTag), .inCond(inCond), .opMulAdd(opMulAdd), .opCmpOrd(opCmpOrd),
		.opCvtInt(opCvtInt), .trapValue(trapValue), .defaultValue(defaultValue),
		.inReady(inReady), .fpExcModeBit0(m0), .fpExcModeBit1(m1),
		.olderDone(olderDone), .trapAck(trapAck), .fpscrAccess(fpscrAccess),
		.syncReq(syncReq), .accessGrant(accessGrant), .wbValid(wbValid), .wbTag(wbTag),
		.wbData(wbData), .wbSuppress(wbSuppress), .excReq(excReq), .excTag(excTag),
		.flushYounger(), .irq(irq)
	);
	fp_completion_model fp_completion_model_inst (
		.clk(clk), .rst(rst), .excReq(excReq), .slow(slow),
		.olderDone(olderDone), .trapAck(trapAck)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [63:0] s, input logic [63:0] e, input string nm);
		n_tests++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic test_done;
		$display("Comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		rq.push_back(e);
		@(posedge clk);
		regRd <= 1'b0;
	endtask

	task automatic set_en(input logic [4:0] v);
		en = v;
		wr(REG_ENABLE, {27'h0, v});
	endtask

	// Lowest invalid wins unless paired with snan by op class; overflow hides underflow
	function automatic logic [11:0] filt(input logic [11:0] c, input logic [2:0] op);
		logic [7:0] k;
		k = c[7:0] & (~c[7:0] + 8'h01);
		if (c[0])
			k = k | (c[7:0] & {op[2], 1'b0, op[1], op[0], 4'h0});
		return {c[11], c[10] & ~c[9], c[9:8], k};
	endfunction

	function automatic logic [31:0] recx(input logic [11:0] f);
		logic [11:0] m;
		m = {en[EN_XE], en[EN_UE], en[EN_OE], en[EN_ZE], {8{en[EN_VE]}}};
		return {18'h0, |(f & m), |f, f};
	endfunction

	task automatic issue(input logic [11:0] c, input logic [2:0] op, input int k = 0);
		logic [63:0] tv;
		logic [63:0] dv;
		logic s;
		logic t;
		int n;
		last = filt(c, op);
		tv = {$random(seed), $random(seed)};
		dv = {$random(seed), $random(seed)};
		s = (|last[7:0] & en[EN_VE]) | (last[C_ZX] & en[EN_ZE]);
		t = (last[C_OX] & en[EN_OE]) | (last[C_UX] & en[EN_UE]) | (last[C_XX] & en[EN_XE]);
		tag = tag + 6'h01;
		for (n = 0; n < 100 && inReady !== 1'b1; n++) @(negedge clk);
		@(posedge clk);
		inValid <= 1'b1;
		inTag <= tag;
		inCond <= c;
		{opCvtInt, opCmpOrd, opMulAdd} <= op;
		trapValue <= tv;
		defaultValue <= dv;
		wq.push_back({s, tag, s ? 64'h0 : (t ? tv : dv)});
		@(posedge clk);
		inValid <= 1'b0;
		fpscrAccess <= (k == 1);
		syncReq <= (k == 2);
		if ((s | t) && (m0 | m1)) begin
			for (n = 0; n < 100 && excReq !== 1'b1; n++) @(negedge clk);
			chk(excTag, tag, "excTag");
			for (n = 0; n < 100 && excReq !== 1'b0; n++) @(negedge clk);
		end
	endtask

	task automatic drain(output int n);
		@(posedge clk);
		fpscrAccess <= 1'b0;
		syncReq <= 1'b0;
		for (n = 1; n < 30 && accessGrant !== 1'b1; n++) @(negedge clk);
		chk(n < 30, 1, "grant");
		rd(REG_RECORD, recx(last));
	endtask

	always @(negedge clk) begin
		if (rdPend)
			chk(regRdData, rq.pop_front(), "rdData");
		rdPend = (regRd === 1'b1);
		if (wbValid === 1'b1) begin
			we = wq.pop_front();
			chk(wbSuppress, we[70], "wbSuppress");
			chk(wbTag, we[69:64], "wbTag");
			chk(wbData, we[63:0], "wbData");
		end
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			test_done();
		end
	end

	initial begin
		seed = 32'h9c40;
		{rst, regWr, regRd, inValid, m0, m1, slow, fpscrAccess, syncReq} = 9'h100;
		{opMulAdd, opCmpOrd, opCvtInt, rdPend, regAddr, regWrData} = '0;
		{inTag, inCond, trapValue, defaultValue, tag, en} = '0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(REG_RECORD, 32'h0);
		rd(REG_IRQ_MASK, 32'h0);
		wr(8'h10, 32'hFFFFFFFF);
		rd(8'h10, 32'h0);
		for (j = 0; j < 2; j++) begin
			set_en(j ? 5'h1F : 5'h00);
			rd(REG_ENABLE, {27'h0, en});
			for (i = 0; i < 8; i++) begin
				wr(REG_RECORD, 32'h0);
				issue(cs[i][11:0], cs[i][14:12]);
				rd(REG_RECORD, recx(last));
			end
		end
		repeat (24) begin
			set_en($random(seed));
			wr(REG_RECORD, 32'h0);
			i = $random(seed);
			issue($random(seed), 3'(4'h1 << i[1:0]));
			rd(REG_RECORD, recx(last));
		end
		wr(REG_IRQ_STATUS, 32'h7);
		wr(REG_IRQ_MASK, 32'h0);
		set_en(5'h08);
		wr(REG_RECORD, 32'h0);
		issue(12'h100, 3'h0);
		rd(REG_IRQ_STATUS, 32'h6);
		chk(irq, 1'b0, "irqMasked");
		wr(REG_IRQ_MASK, 32'h2);
		repeat (2) @(negedge clk);
		chk(irq, 1'b1, "irqRaised");
		wr(REG_IRQ_STATUS, 32'h6);
		repeat (2) @(negedge clk);
		chk(irq, 1'b0, "irqCleared");
		rd(REG_IRQ_STATUS, 32'h0);
		for (i = 1; i < 8; i++) begin
			@(posedge clk);
			{slow, m1, m0} <= 3'(i);
			set_en(5'h1F);
			issue(12'h100, 3'h0);
			issue(12'h200, 3'h0);
			issue(12'h011, 3'h1);
			set_en(5'h00);
			issue(12'h100, 3'h0);
			chk(excReq, 1'b0, "noRequest");
		end
		@(posedge clk);
		{slow, m1, m0} <= 3'h0;
		wr(REG_RECORD, 32'h0);
		issue(12'h800, 3'h0, 1);
		drain(na);
		wr(REG_RECORD, 32'h0);
		issue(12'h300, 3'h0, 2);
		drain(ns);
		chk(ns >= SYNC_DRAIN_CYC, 1, "syncStall");
		repeat (4) @(posedge clk);
		test_done();
	end
endmodule
